/* File: verif/rsfs_panel.sv */
module rsfs_panel (
  output logic [7:0] term_in,
  output logic [39:0] term_code,
  output logic [1:0] body_keys,
  output logic [1:0] remote_keys,
  output logic present,
  output logic [1:0] serial_cmd,
  output logic [15:0] serial_freq
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Terminals, keypads and serial master
  // ****************************************
  // One wiring plan for all tests: run, reverse, up, down, hold, three step bits
  assign term_code = {5'h07, 5'h06, 5'h05, 5'h17, 5'h10, 5'h0f, 5'h01, 5'h00};
  initial begin
    term_in = 8'h00;
    body_keys = 2'h0;
    remote_keys = 2'h0;
    present = 1'b0;
    serial_cmd = 2'h0;
    serial_freq = 16'h0000;
  end
  // Called at the falling edge only, so levels never move on the sampling edge
  task set_terms(input logic [7:0] v);
    term_in = v;
  endtask
  task set_keys(input logic [1:0] b, input logic [1:0] r, input logic p);
    body_keys = b;
    remote_keys = r;
    present = p;
  endtask
  task set_serial(input logic [1:0] c, input logic [15:0] f);
    serial_cmd = c;
    serial_freq = f;
  endtask
endmodule

/* File: verif/rsfs_top_properties.sv */
module rsfs_top_check #(
  parameter int UPDOWN_STEP_CYCLES = rsfs_pkg::UPDOWN_STEP_CYCLES
) (
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic [rsfs_pkg::TERM_N-1:0] TERM_IN,
  input wire logic [3:0] FREQ_MODE,
  input wire logic [1:0] RUN_SRC,
  input wire logic [1:0] DIRECTION_INHIBIT,
  input wire rsfs_pkg::rsfs_keys_t BODY_KEYS,
  input wire rsfs_pkg::rsfs_keys_t REMOTE_KEYS,
  input wire logic REMOTE_KEYPAD_PRESENT,
  input wire rsfs_pkg::rsfs_freq_t KEYPAD_FREQ,
  input wire rsfs_pkg::rsfs_freq_t MAX_FREQUENCY_LIMIT,
  input wire logic FAULT_ACTIVE,
  input wire rsfs_pkg::rsfs_freq_t FREQ_REF,
  input wire rsfs_pkg::rsfs_cmd_t DRIVE_CMD,
  input wire logic FREQ_REFUSED,
  input wire logic [2:0] STEP_INDEX
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Port relations
  // ****************************************
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RESET);
  AST_RESET_IDLE: assert property ($fell(RESET) |-> DRIVE_CMD == 2'h0
    && !FREQ_REFUSED && STEP_INDEX == 3'h0) else $error("outputs busy after reset");
  AST_FAULT_STOP: assert property (FAULT_ACTIVE |=> !DRIVE_CMD.run)
    else $error("run during fault");
  AST_NO_FWD: assert property ($past(DIRECTION_INHIBIT) == 2'h1
    |-> !(DRIVE_CMD.run && !DRIVE_CMD.reverse)) else $error("forward run while blocked");
  AST_NO_REV: assert property ($past(DIRECTION_INHIBIT) == 2'h2
    |-> !(DRIVE_CMD.run && DRIVE_CMD.reverse)) else $error("reverse run while blocked");
  AST_REFUSE_HOLDS: assert property (FREQ_REFUSED |-> $stable(FREQ_REF))
    else $error("reference moved on refusal");
  AST_BELOW_LIMIT: assert property (!$past(RESET) && $changed(FREQ_REF)
    |-> FREQ_REF < $past(MAX_FREQUENCY_LIMIT)) else $error("reference at or over limit");
  AST_BASE_SOURCE: assert property (!$past(RESET) && $past(FREQ_MODE) == 4'h0
    && $past(TERM_IN) == 8'h00 && $past(KEYPAD_FREQ) < $past(MAX_FREQUENCY_LIMIT)
    |-> FREQ_REF == $past(KEYPAD_FREQ)) else $error("keypad value not taken");
  AST_BASE_REFUSE: assert property (!$past(RESET) && $past(FREQ_MODE) == 4'h0
    && $past(TERM_IN) == 8'h00 && $past(KEYPAD_FREQ) >= $past(MAX_FREQUENCY_LIMIT)
    |-> FREQ_REFUSED) else $error("over limit not refused");
  AST_STOP_KEY: assert property (RUN_SRC == 2'h0 && !REMOTE_KEYPAD_PRESENT
    && BODY_KEYS.stop |-> ##2 !DRIVE_CMD.run) else $error("stop key ignored");
  // Three quiet cycles rule out a run press latched just before the window
  AST_REMOTE_ONLY: assert property ((RUN_SRC == 2'h0 && REMOTE_KEYPAD_PRESENT
    && !REMOTE_KEYS.run && !DRIVE_CMD.run) [*3] |=> !DRIVE_CMD.run)
    else $error("body key used with remote keypad");
  AST_DIR_ON_ENTRY: assert property (DRIVE_CMD.run && $past(DRIVE_CMD.run)
    |-> $stable(DRIVE_CMD.reverse)) else $error("direction flipped while running");
endmodule

bind rsfs_top rsfs_top_check #(.UPDOWN_STEP_CYCLES(UPDOWN_STEP_CYCLES)) rsfs_top_check_i (
  .REF_CLK(REF_CLK), .RESET(RESET), .TERM_IN(TERM_IN), .FREQ_MODE(FREQ_MODE),
  .RUN_SRC(RUN_SRC), .DIRECTION_INHIBIT(DIRECTION_INHIBIT), .BODY_KEYS(BODY_KEYS),
  .REMOTE_KEYS(REMOTE_KEYS), .REMOTE_KEYPAD_PRESENT(REMOTE_KEYPAD_PRESENT),
  .KEYPAD_FREQ(KEYPAD_FREQ), .MAX_FREQUENCY_LIMIT(MAX_FREQUENCY_LIMIT),
  .FAULT_ACTIVE(FAULT_ACTIVE), .FREQ_REF(FREQ_REF), .DRIVE_CMD(DRIVE_CMD),
  .FREQ_REFUSED(FREQ_REFUSED), .STEP_INDEX(STEP_INDEX));

/* File: verif/testbench.sv */
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk;
  logic rst;
  logic fault;
  logic stopped;
  logic dsel;
  logic auto_on;
  logic restart;
  logic neg;
  logic [3:0] mode;
  logic [1:0] rsrc;
  logic [1:0] inhibit;
  logic [15:0] kfreq;
  logic [15:0] bip = 16'h07d0;
  logic [15:0] uni;
  logic [15:0] cur;
  logic [15:0] limit = 16'h1388;
  logic [47:0] grp_a = {16'h012c, 16'h00c8, 16'h0064};
  logic [63:0] grp_b = {16'h02bc, 16'h0258, 16'h01f4, 16'h0190};
  logic [7:0] term;
  logic [39:0] codes;
  logic [1:0] bkeys, rkeys, scmd, cmd;
  logic present, refused;
  logic [15:0] sfreq, fref;
  logic [2:0] step;
  int num_errors = 0;
  int check_count = 0;
  // ****************************************
  // Clock, core model and instances
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Core reports standstill at the falling edge after run drops, no real ramp
  always @(negedge clk) stopped <= !cmd[1];
  rsfs_panel rsfs_panel_i (.term_in(term), .term_code(codes), .body_keys(bkeys),
    .remote_keys(rkeys), .present(present), .serial_cmd(scmd), .serial_freq(sfreq));
  rsfs_top #(.UPDOWN_STEP_CYCLES(4)) rsfs_top_i (.REF_CLK(clk), .RESET(rst),
    .TERM_IN(term), .TERM_CODE(codes), .FREQ_MODE(mode), .RUN_SRC(rsrc),
    .KEYPAD_DIRECTION_SEL(dsel), .DIRECTION_INHIBIT(inhibit), .POWER_ON_AUTOSTART(auto_on),
    .RESTART_AFTER_FAULT(restart), .BODY_KEYS(bkeys), .REMOTE_KEYS(rkeys),
    .REMOTE_KEYPAD_PRESENT(present), .KEYPAD_FREQ(kfreq), .BIPOLAR_VOLTAGE_INPUT(bip),
    .BIPOLAR_NEGATIVE(neg), .UNIPOLAR_FREQ(uni), .CURRENT_FREQ(cur), .SERIAL_FREQ(sfreq),
    .SERIAL_CMD(scmd), .PRESET_GROUP_A(grp_a), .PRESET_GROUP_B(grp_b),
    .MAX_FREQUENCY_LIMIT(limit), .FAULT_ACTIVE(fault), .MOTOR_STOPPED(stopped),
    .FREQ_REF(fref), .DRIVE_CMD(cmd), .FREQ_REFUSED(refused), .STEP_INDEX(step));
  // ****************************************
  // Tasks
  // ****************************************
  task settle(input int n);
    repeat (n) @(negedge clk);
  endtask
  task do_reset;
    rst = 1'b1;
    settle(6);
    rst = 1'b0;
  endtask
  task check_value(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Bounded waits: latency differs by source, the final value is what counts
  task await_cmd(input logic [1:0] c, input logic [1:0] m);
    int n;
    n = 0;
    while ((cmd & m) !== c && n < 30) begin
      settle(1);
      n++;
    end
    check_value({14'h0, cmd & m}, {14'h0, c});
  endtask
  task await_freq(input logic [15:0] f);
    int n;
    n = 0;
    while (fref !== f && n < 40) begin
      settle(1);
      n++;
    end
    check_value(fref, f);
  endtask
  task summarize;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    #20000;
    num_errors++;
    summarize();
  end
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    fault = 1'b0;
    dsel = 1'b0;
    auto_on = 1'b0;
    restart = 1'b0;
    neg = 1'b0;
    mode = 4'h0;
    rsrc = 2'h1;
    inhibit = 2'h0;
    kfreq = 16'h03e8;
    uni = 16'h0258;
    cur = 16'h0064;
    // Skip the time-zero clock step so reset spans six full cycles
    wait (clk === 1'b0);
    do_reset();
    check_value({14'h0, cmd}, 16'h0000);
    await_freq(16'h03e8);
    kfreq = 16'h1388;
    settle(3);
    check_value(fref, 16'h03e8);
    check_value({15'h0, refused}, 16'h0001);
    kfreq = 16'h1387;
    await_freq(16'h1387);
    rsfs_panel_i.set_terms(8'h01);
    await_cmd(2'h2, 2'h3);
    for (int k = 1; k < 8; k++) begin
      rsfs_panel_i.set_terms({k[2:0], 5'h01});
      await_freq(16'(k * 100));
      check_value({13'h0, step}, 16'(k));
    end
    rsfs_panel_i.set_terms(8'h01);
    await_freq(16'h1387);
    inhibit = 2'h1;
    await_cmd(2'h0, 2'h2);
    rsfs_panel_i.set_terms(8'h02);
    inhibit = 2'h0;
    await_cmd(2'h3, 2'h3);
    inhibit = 2'h2;
    await_cmd(2'h0, 2'h2);
    rsfs_panel_i.set_terms(8'h00);
    settle(2);
    inhibit = 2'h0;
    rsfs_panel_i.set_terms(8'h03);
    settle(4);
    check_value({14'h0, cmd & 2'h2}, 16'h0000);
    rsfs_panel_i.set_terms(8'h00);
    rsrc = 2'h2;
    settle(2);
    rsfs_panel_i.set_terms(8'h01);
    await_cmd(2'h2, 2'h3);
    rsfs_panel_i.set_terms(8'h03);
    await_cmd(2'h3, 2'h3);
    rsfs_panel_i.set_terms(8'h01);
    mode = 4'h2;
    await_freq(16'h07d0);
    await_cmd(2'h2, 2'h3);
    neg = 1'b1;
    await_cmd(2'h3, 2'h3);
    neg = 1'b0;
    await_cmd(2'h2, 2'h3);
    mode = 4'h3;
    await_freq(16'h0258);
    rsfs_panel_i.set_terms(8'h11);
    settle(2);
    uni = 16'h0320;
    settle(4);
    check_value(fref, 16'h0258);
    rsfs_panel_i.set_terms(8'h01);
    await_freq(16'h0320);
    mode = 4'h0;
    rsfs_panel_i.set_terms(8'h11);
    kfreq = 16'h0190;
    await_freq(16'h0190);
    rsfs_panel_i.set_terms(8'h01);
    mode = 4'h6;
    await_freq(16'h0384);
    cur = 16'h0900;
    mode = 4'h4;
    await_freq(16'h0900);
    mode = 4'h5;
    await_freq(16'h10d0);
    neg = 1'b1;
    await_freq(16'h0130);
    neg = 1'b0;
    rsfs_panel_i.set_serial(2'h0, 16'h0456);
    mode = 4'h7;
    await_freq(16'h0456);
    mode = 4'h8;
    rsfs_panel_i.set_terms(8'h05);
    await_freq(16'h0003);
    rsfs_panel_i.set_terms(8'h09);
    await_freq(16'h0001);
    rsfs_panel_i.set_terms(8'h01);
    mode = 4'h0;
    fault = 1'b1;
    await_cmd(2'h0, 2'h2);
    fault = 1'b0;
    settle(5);
    check_value({14'h0, cmd & 2'h2}, 16'h0000);
    fault = 1'b1;
    restart = 1'b1;
    settle(2);
    fault = 1'b0;
    await_cmd(2'h2, 2'h2);
    rsrc = 2'h3;
    rsfs_panel_i.set_terms(8'h00);
    rsfs_panel_i.set_serial(2'h3, 16'h0456);
    await_cmd(2'h3, 2'h3);
    rsfs_panel_i.set_serial(2'h0, 16'h0456);
    await_cmd(2'h0, 2'h2);
    rsrc = 2'h0;
    dsel = 1'b1;
    rsfs_panel_i.set_keys(2'h2, 2'h0, 1'b1);
    settle(5);
    check_value({14'h0, cmd & 2'h2}, 16'h0000);
    rsfs_panel_i.set_keys(2'h0, 2'h0, 1'b0);
    settle(1);
    rsfs_panel_i.set_keys(2'h2, 2'h0, 1'b0);
    settle(2);
    rsfs_panel_i.set_keys(2'h0, 2'h0, 1'b0);
    await_cmd(2'h3, 2'h3);
    rsfs_panel_i.set_keys(2'h1, 2'h0, 1'b0);
    await_cmd(2'h0, 2'h2);
    rsfs_panel_i.set_keys(2'h0, 2'h0, 1'b0);
    rsrc = 2'h1;
    rsfs_panel_i.set_terms(8'h01);
    auto_on = 1'b1;
    do_reset();
    await_cmd(2'h2, 2'h2);
    auto_on = 1'b0;
    do_reset();
    settle(5);
    check_value({14'h0, cmd & 2'h2}, 16'h0000);
    summarize();
  end
endmodule

/* File: verilog/rsfs_pkg.sv */
package rsfs_pkg;

  // ************************************************************
  // Widths and types
  // ************************************************************
  localparam int FREQ_W = 16;
  localparam int CODE_W = 5;
  localparam int TERM_N = 8;

  typedef logic [FREQ_W-1:0] rsfs_freq_t;
  typedef logic [CODE_W-1:0] rsfs_code_t;

  typedef struct packed {
    logic run;
    logic stop;
  } rsfs_keys_t;

  typedef struct packed {
    logic run;
    logic reverse;
  } rsfs_cmd_t;

  // ************************************************************
  // Frequency source settings
  // ************************************************************
  localparam logic [3:0] FSRC_KEYPAD1 = 4'h0;
  localparam logic [3:0] FSRC_KEYPAD2 = 4'h1;
  localparam logic [3:0] FSRC_BIPOLAR = 4'h2;
  localparam logic [3:0] FSRC_UNIPOLAR = 4'h3;
  localparam logic [3:0] FSRC_CURRENT = 4'h4;
  localparam logic [3:0] FSRC_BIP_CURR = 4'h5;
  localparam logic [3:0] FSRC_UNI_CURR = 4'h6;
  localparam logic [3:0] FSRC_SERIAL = 4'h7;
  localparam logic [3:0] FSRC_UPDOWN = 4'h8;
  localparam logic [3:0] FSRC_HOLD_LO = 4'h2;
  localparam logic [3:0] FSRC_HOLD_HI = 4'h7;

  // ************************************************************
  // Run source settings and direction inhibit
  // ************************************************************
  localparam logic [1:0] RSRC_KEYPAD = 2'h0;
  localparam logic [1:0] RSRC_FWD_REV = 2'h1;
  localparam logic [1:0] RSRC_RUN_DIR = 2'h2;
  localparam logic [1:0] RSRC_SERIAL = 2'h3;
  localparam logic [1:0] INHIBIT_NONE = 2'h0;
  localparam logic [1:0] INHIBIT_FWD = 2'h1;
  localparam logic [1:0] INHIBIT_REV = 2'h2;

  // ************************************************************
  // Terminal function codes
  // ************************************************************
  localparam rsfs_code_t FCODE_FX = 5'h00;
  localparam rsfs_code_t FCODE_RX = 5'h01;
  localparam rsfs_code_t FCODE_STEP0 = 5'h05;
  localparam rsfs_code_t FCODE_STEP1 = 5'h06;
  localparam rsfs_code_t FCODE_STEP2 = 5'h07;
  localparam rsfs_code_t FCODE_UP = 5'h0f;
  localparam rsfs_code_t FCODE_DOWN = 5'h10;
  localparam rsfs_code_t FCODE_HOLD = 5'h17;

  // ************************************************************
  // Reset values (0.01 Hz units) and timing
  // ************************************************************
  localparam rsfs_freq_t MAX_FREQ_RST = 16'h1388;
  localparam rsfs_freq_t UPDOWN_STEP = 16'h0001;
  localparam int UPDOWN_STEP_NS = 50000;
  localparam int CLK_PERIOD_NS = 5;
  localparam int UPDOWN_STEP_CYCLES = UPDOWN_STEP_NS / CLK_PERIOD_NS;

endpackage

/* File: verilog/rsfs_term_match.sv */
module rsfs_term_match #(
  parameter rsfs_pkg::rsfs_code_t CODE = 5'h00
) (
  input wire logic [rsfs_pkg::TERM_N-1:0] levels,
  input wire rsfs_pkg::rsfs_code_t [rsfs_pkg::TERM_N-1:0] codes,
  output logic hit
);

  // Several terminals may carry the same code; any active one counts
  always_comb begin
    hit = 1'b0;
    for (int i = 0; i < rsfs_pkg::TERM_N; i++) begin
      if (levels[i] && codes[i] == CODE) begin
        hit = 1'b1;
      end
    end
  end

endmodule

/* File: verilog/rsfs_top.sv */
// How it works
// [RULE1] Source 6 sums the scaled unipolar voltage and current inputs.
// [RULE2] Source 7 takes the frequency written over the serial link.
// [RULE3] Source 8 ramps frequency up or down from two terminals.
// [RULE4] Analog hold terminal, code 23, works only with source 2 to 7.
// [RULE5] Hold while running freezes the reference captured at hold onset.
// [RULE6] Terminals coded 5, 6, 7 form step index bits, low to high.
// [RULE7] While running, nonzero step index selects a preset; zero uses base source.
// [RULE8] Presets 1 to 3 and 4 to 7 arrive as two setting groups.
// [RULE9] Run source 0: keypad run key starts if frequency set; stop key stops.
// [RULE10] Keypad runs take direction from the keypad direction setting.
// [RULE11] Run source 1: forward terminal runs forward, reverse terminal reverse.
// [RULE12] Run source 2: code 0 terminal runs, code 1 terminal picks reverse.
// [RULE13] Run source 3: run and stop come from the serial link.
// [RULE14] Source 2 with negative bipolar input inverts the commanded direction.
// [RULE15] Polarity flip while running: stop first, then run the other way.
// [RULE16] Direction inhibit: 0 none, 1 blocks forward, 2 blocks reverse.
// [RULE17] Autostart at power-up with terminal run sources if terminal is active.
// [RULE18] Restart on fault clear with terminal run sources if terminal active.
// [RULE19] A connected remote keypad disables the built-in keypad keys.
// [RULE20] Source 2 uses the bipolar voltage input as reference.
// [RULE21] A frequency command at or above the maximum limit is refused.
// [RULE22] Without steps or overrides the configured source is used, keypad by default.
module rsfs_top #(
  parameter int UPDOWN_STEP_CYCLES = rsfs_pkg::UPDOWN_STEP_CYCLES
) (
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic [rsfs_pkg::TERM_N-1:0] TERM_IN,
  input wire rsfs_pkg::rsfs_code_t [rsfs_pkg::TERM_N-1:0] TERM_CODE,
  input wire logic [3:0] FREQ_MODE,
  input wire logic [1:0] RUN_SRC,
  input wire logic KEYPAD_DIRECTION_SEL,
  input wire logic [1:0] DIRECTION_INHIBIT,
  input wire logic POWER_ON_AUTOSTART,
  input wire logic RESTART_AFTER_FAULT,
  input wire rsfs_pkg::rsfs_keys_t BODY_KEYS,
  input wire rsfs_pkg::rsfs_keys_t REMOTE_KEYS,
  input wire logic REMOTE_KEYPAD_PRESENT,
  input wire rsfs_pkg::rsfs_freq_t KEYPAD_FREQ,
  input wire rsfs_pkg::rsfs_freq_t BIPOLAR_VOLTAGE_INPUT,
  input wire logic BIPOLAR_NEGATIVE,
  input wire rsfs_pkg::rsfs_freq_t UNIPOLAR_FREQ,
  input wire rsfs_pkg::rsfs_freq_t CURRENT_FREQ,
  input wire rsfs_pkg::rsfs_freq_t SERIAL_FREQ,
  input wire rsfs_pkg::rsfs_cmd_t SERIAL_CMD,
  input wire rsfs_pkg::rsfs_freq_t [3:1] PRESET_GROUP_A,
  input wire rsfs_pkg::rsfs_freq_t [7:4] PRESET_GROUP_B,
  input wire rsfs_pkg::rsfs_freq_t MAX_FREQUENCY_LIMIT,
  input wire logic FAULT_ACTIVE,
  input wire logic MOTOR_STOPPED,
  output rsfs_pkg::rsfs_freq_t FREQ_REF,
  output rsfs_pkg::rsfs_cmd_t DRIVE_CMD,
  output logic FREQ_REFUSED,
  output logic [2:0] STEP_INDEX
);

  // ************************************************************
  // Terminal decode
  // ************************************************************
  logic fx_on;
  logic rx_on;
  logic up_on;
  logic down_on;
  logic hold_on;
  logic [2:0] step_bits;

  rsfs_term_match #(.CODE(rsfs_pkg::FCODE_FX)) u_fx (
    .levels(TERM_IN), .codes(TERM_CODE), .hit(fx_on));
  rsfs_term_match #(.CODE(rsfs_pkg::FCODE_RX)) u_rx (
    .levels(TERM_IN), .codes(TERM_CODE), .hit(rx_on));
  rsfs_term_match #(.CODE(rsfs_pkg::FCODE_UP)) u_up (
    .levels(TERM_IN), .codes(TERM_CODE), .hit(up_on));
  rsfs_term_match #(.CODE(rsfs_pkg::FCODE_DOWN)) u_down (
    .levels(TERM_IN), .codes(TERM_CODE), .hit(down_on));
  rsfs_term_match #(.CODE(rsfs_pkg::FCODE_HOLD)) u_hold (
    .levels(TERM_IN), .codes(TERM_CODE), .hit(hold_on));
  rsfs_term_match #(.CODE(rsfs_pkg::FCODE_STEP0)) u_s0 (
    .levels(TERM_IN), .codes(TERM_CODE), .hit(step_bits[0])); // [RULE6]
  rsfs_term_match #(.CODE(rsfs_pkg::FCODE_STEP1)) u_s1 (
    .levels(TERM_IN), .codes(TERM_CODE), .hit(step_bits[1])); // [RULE6]
  rsfs_term_match #(.CODE(rsfs_pkg::FCODE_STEP2)) u_s2 (
    .levels(TERM_IN), .codes(TERM_CODE), .hit(step_bits[2])); // [RULE6]

  // ************************************************************
  // Up-down digital volume
  // ************************************************************
  rsfs_pkg::rsfs_freq_t updown_freq;

  rsfs_updown #(.STEP_CYCLES(UPDOWN_STEP_CYCLES)) u_updown (
    .clk(REF_CLK),
    .rst(RESET),
    .up(up_on && FREQ_MODE == rsfs_pkg::FSRC_UPDOWN), // [RULE3]
    .down(down_on && FREQ_MODE == rsfs_pkg::FSRC_UPDOWN), // [RULE3]
    .max_freq(MAX_FREQUENCY_LIMIT),
    .value(updown_freq)
  );

  // ************************************************************
  // Keypad run latch
  // ************************************************************
  rsfs_pkg::rsfs_keys_t keys;
  logic key_run;

  assign keys = REMOTE_KEYPAD_PRESENT ? REMOTE_KEYS : BODY_KEYS; // [RULE19]

  // Stop wins over run when both keys arrive together
  always_ff @(posedge REF_CLK) begin
    if (RESET || RUN_SRC != rsfs_pkg::RSRC_KEYPAD || FAULT_ACTIVE) begin
      key_run <= 1'b0;
    end else if (keys.stop) begin
      key_run <= 1'b0; // [RULE9]
    end else if (keys.run && FREQ_REF != '0) begin
      key_run <= 1'b1; // [RULE9]
    end
  end

  // ************************************************************
  // Terminal run arming
  // ************************************************************
  logic term_src;
  logic term_level;
  logic term_armed;
  logic first_cycle;
  logic fault_q;

  assign term_src = (RUN_SRC == rsfs_pkg::RSRC_FWD_REV) || (RUN_SRC == rsfs_pkg::RSRC_RUN_DIR);
  assign term_level = (RUN_SRC == rsfs_pkg::RSRC_FWD_REV) ? (fx_on ^ rx_on) : fx_on;

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      first_cycle <= 1'b1;
      fault_q <= 1'b0;
    end else begin
      first_cycle <= 1'b0;
      fault_q <= FAULT_ACTIVE;
    end
  end

  // A terminal held on must be cycled before it runs, unless a start option applies
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      term_armed <= 1'b0;
    end else if (first_cycle) begin
      term_armed <= !term_level || (POWER_ON_AUTOSTART && term_src); // [RULE17]
    end else if (FAULT_ACTIVE) begin
      term_armed <= 1'b0;
    end else if (fault_q) begin
      term_armed <= !term_level || (RESTART_AFTER_FAULT && term_src); // [RULE18]
    end else if (!term_level) begin
      term_armed <= 1'b1;
    end
  end

  // ************************************************************
  // Requested run and direction
  // ************************************************************
  rsfs_pkg::rsfs_cmd_t req;
  logic want_rev;
  logic blocked;

  always_comb begin
    req = '0;
    case (RUN_SRC)
      rsfs_pkg::RSRC_KEYPAD: begin
        req.run = key_run;
        req.reverse = KEYPAD_DIRECTION_SEL; // [RULE10]
      end
      rsfs_pkg::RSRC_FWD_REV: begin
        req.run = term_level && term_armed; // [RULE11]
        req.reverse = rx_on && !fx_on; // [RULE11]
      end
      rsfs_pkg::RSRC_RUN_DIR: begin
        req.run = term_level && term_armed; // [RULE12]
        req.reverse = rx_on; // [RULE12]
      end
      rsfs_pkg::RSRC_SERIAL: begin
        req = SERIAL_CMD; // [RULE13]
      end
      default: begin
        req = '0;
      end
    endcase
    if (FAULT_ACTIVE) begin
      req.run = 1'b0;
    end
  end

  // Negative bipolar input swaps direction in source 2, whatever the run source
  assign want_rev = req.reverse ^ (FREQ_MODE == rsfs_pkg::FSRC_BIPOLAR && BIPOLAR_NEGATIVE); // [RULE14]
  assign blocked = (!want_rev && DIRECTION_INHIBIT == rsfs_pkg::INHIBIT_FWD) ||
                   (want_rev && DIRECTION_INHIBIT == rsfs_pkg::INHIBIT_REV); // [RULE16]

  // ************************************************************
  // Run sequencer
  // ************************************************************
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_REVERSING} rsfs_state_t;
  rsfs_state_t state;
  rsfs_state_t next_state;

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (req.run && !blocked) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!req.run || blocked) begin
          next_state = ST_IDLE;
        end else if (want_rev != DRIVE_CMD.reverse) begin
          next_state = ST_REVERSING; // [RULE15]
        end
      end
      ST_REVERSING: begin
        if (!req.run || blocked) begin
          next_state = ST_IDLE;
        end else if (MOTOR_STOPPED) begin
          next_state = ST_RUN; // [RULE15]
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Direction only changes from idle or after the motor has stopped
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      DRIVE_CMD <= '0;
    end else begin
      DRIVE_CMD.run <= (next_state == ST_RUN); // [RULE15]
      if (next_state == ST_RUN && state != ST_RUN) begin
        DRIVE_CMD.reverse <= want_rev; // [RULE16]
      end
    end
  end

  // ************************************************************
  // Frequency source select
  // ************************************************************
  rsfs_pkg::rsfs_freq_t base_freq;
  rsfs_pkg::rsfs_freq_t step_freq;
  rsfs_pkg::rsfs_freq_t held_freq;
  rsfs_pkg::rsfs_freq_t cand_freq;
  logic [rsfs_pkg::FREQ_W:0] sum_freq;
  logic hold_allowed;
  logic hold_q;

  always_comb begin
    sum_freq = '0;
    case (FREQ_MODE)
      rsfs_pkg::FSRC_BIPOLAR: base_freq = BIPOLAR_VOLTAGE_INPUT; // [RULE20]
      rsfs_pkg::FSRC_UNIPOLAR: base_freq = UNIPOLAR_FREQ;
      rsfs_pkg::FSRC_CURRENT: base_freq = CURRENT_FREQ;
      rsfs_pkg::FSRC_BIP_CURR: begin
        if (BIPOLAR_NEGATIVE) begin
          sum_freq = (CURRENT_FREQ > BIPOLAR_VOLTAGE_INPUT) ?
                     {1'b0, CURRENT_FREQ - BIPOLAR_VOLTAGE_INPUT} : '0;
        end else begin
          sum_freq = {1'b0, CURRENT_FREQ} + {1'b0, BIPOLAR_VOLTAGE_INPUT};
        end
        base_freq = sum_freq[rsfs_pkg::FREQ_W] ? '1 : sum_freq[rsfs_pkg::FREQ_W-1:0];
      end
      rsfs_pkg::FSRC_UNI_CURR: begin
        sum_freq = {1'b0, UNIPOLAR_FREQ} + {1'b0, CURRENT_FREQ}; // [RULE1]
        base_freq = sum_freq[rsfs_pkg::FREQ_W] ? '1 : sum_freq[rsfs_pkg::FREQ_W-1:0];
      end
      rsfs_pkg::FSRC_SERIAL: base_freq = SERIAL_FREQ; // [RULE2]
      rsfs_pkg::FSRC_UPDOWN: base_freq = updown_freq; // [RULE3]
      default: base_freq = KEYPAD_FREQ; // [RULE22]
    endcase
  end

  always_comb begin
    case (step_bits)
      3'h1: step_freq = PRESET_GROUP_A[1]; // [RULE8]
      3'h2: step_freq = PRESET_GROUP_A[2];
      3'h3: step_freq = PRESET_GROUP_A[3];
      3'h4: step_freq = PRESET_GROUP_B[4]; // [RULE8]
      3'h5: step_freq = PRESET_GROUP_B[5];
      3'h6: step_freq = PRESET_GROUP_B[6];
      3'h7: step_freq = PRESET_GROUP_B[7];
      default: step_freq = base_freq;
    endcase
  end

  assign hold_allowed = hold_on && FREQ_MODE >= rsfs_pkg::FSRC_HOLD_LO &&
                        FREQ_MODE <= rsfs_pkg::FSRC_HOLD_HI; // [RULE4]

  // Captured on the hold onset so analog drift during hold has no effect
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      hold_q <= 1'b0;
      held_freq <= '0;
    end else begin
      hold_q <= hold_allowed && DRIVE_CMD.run;
      if (!hold_q) begin
        held_freq <= FREQ_REF; // [RULE5]
      end
    end
  end

  always_comb begin
    if (hold_q && hold_allowed && DRIVE_CMD.run) begin
      cand_freq = held_freq; // [RULE5]
    end else if (req.run && step_bits != 3'h0) begin
      cand_freq = step_freq; // [RULE7]
    end else begin
      cand_freq = base_freq; // [RULE22]
    end
  end

  // A refused command leaves the last accepted reference in place
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      FREQ_REF <= '0;
      FREQ_REFUSED <= 1'b0;
      STEP_INDEX <= 3'h0;
    end else begin
      FREQ_REFUSED <= (cand_freq >= MAX_FREQUENCY_LIMIT); // [RULE21]
      if (cand_freq < MAX_FREQUENCY_LIMIT) begin
        FREQ_REF <= cand_freq; // [RULE21]
      end
      STEP_INDEX <= req.run ? step_bits : 3'h0; // [RULE7]
    end
  end

endmodule

/* File: verilog/rsfs_updown.sv */
module rsfs_updown #(
  parameter int STEP_CYCLES = rsfs_pkg::UPDOWN_STEP_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic up,
  input wire logic down,
  input wire rsfs_pkg::rsfs_freq_t max_freq,
  output rsfs_pkg::rsfs_freq_t value
);

  logic [31:0] tick_cnt;
  logic tick;

  assign tick = (tick_cnt == 32'(STEP_CYCLES - 1));

  // ************************************************************
  // Ramp rate divider
  // ************************************************************
  always_ff @(posedge clk) begin
    if (rst || (up == down) || tick) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick_cnt + 32'h1;
    end
  end

  // Kept strictly below the limit so the value is always acceptable
  always_ff @(posedge clk) begin
    if (rst) begin
      value <= '0;
    end else if (tick && up && !down && (value + rsfs_pkg::UPDOWN_STEP) < max_freq) begin
      value <= value + rsfs_pkg::UPDOWN_STEP;
    end else if (tick && down && !up && value >= rsfs_pkg::UPDOWN_STEP) begin
      value <= value - rsfs_pkg::UPDOWN_STEP;
    end
  end

endmodule
